// [hdl/irf_top.sv]
// Interrupt request flag registers with Avalon-MM slave
// Operation
// - A flag goes to one on its request event and stays set.
// - Accepting an interrupt never clears a flag; only a write does.
// - Bit 7 sets on sleep direct transition while direct transition control is on.
// - Bit 6 sets when conversion running status falls to zero.
// - Bit 3 sets on upper byte match (8-bit) or full match (16-bit).
// - Bit 2 sets on lower byte match, only in 8-bit timer mode.
// - Bit 0 sets on upper overflow, or either byte overflow in 8-bit mode.
// - Writing zero clears a set flag; writing one changes nothing.
// - A wakeup flag sets on the selected edge of an enabled pin.
// - Writing zero to a wakeup flag clears it.
// - Edge select zero senses falling, one senses rising.
`timescale 1ns/1ps
module irf_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [irf_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [irf_pkg::DATA_W-1:0] writedata,
    output logic [irf_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic sleep_direct_transition,
    input wire logic conversion_running_status,
    input wire logic [15:0] timer_count_full,
    input wire logic [15:0] timer_compare_full,
    input wire logic event_count_upper_ovf,
    input wire logic event_count_lower_ovf,
    input wire logic [irf_pkg::FLAG_W-1:0] wakeup_pin_n,
    output logic [irf_pkg::FLAG_W-1:0] peripheral_request_flags,
    output logic [irf_pkg::FLAG_W-1:0] wakeup_request_flags,
    output logic irq
);
    import irf_pkg::*;

    typedef struct packed {
        irf_bus_state_t bus;
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
        logic [FLAG_W-1:0] edge_select;
        logic [FLAG_W-1:0] wake_enable;
        logic [FLAG_W-1:0] ctrl;
        logic [FLAG_W-1:0] irq_status;
        logic [FLAG_W-1:0] irq_mask;
        logic conv_prev;
        logic match_hi_prev;
        logic match_lo_prev;
        logic irq;
    } irf_top_state_t;

    irf_top_state_t st;
    irf_top_state_t next_st;

    logic accept;
    logic wr_lane;
    logic [FLAG_W-1:0] wdata8;
    logic [FLAG_W-1:0] set_periph;
    logic [FLAG_W-1:0] wake_hit;
    logic [FLAG_W-1:0] periph_flags;
    logic [FLAG_W-1:0] wake_flags;
    logic [FLAG_W-1:0] irq_set;
    logic [FLAG_W-1:0] irq_clr;
    logic [FLAG_W-1:0] rd8;
    logic timer16;
    logic event16;
    logic match_full;
    logic match_hi;
    logic match_lo;
    logic wr_periph;
    logic wr_wake;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, then the access takes effect
    assign accept = (st.bus == IRF_BUS_ACK) && (read || write);
    assign wr_lane = accept && write && byteenable[0];
    assign wdata8 = writedata[FLAG_W-1:0];
    assign wr_periph = wr_lane && (address == OFS_PERIPH);
    assign wr_wake = wr_lane && (address == OFS_WAKE);
    assign timer16 = st.ctrl[CTRL_TIMER16];
    assign event16 = st.ctrl[CTRL_EVENT16];

    always_comb begin
        case (address)
            OFS_PERIPH: rd8 = periph_flags;
            OFS_WAKE: rd8 = wake_flags;
            OFS_EDGE_SEL: rd8 = st.edge_select;
            OFS_WAKE_EN: rd8 = st.wake_enable;
            OFS_CTRL: rd8 = st.ctrl;
            OFS_IRQ_STAT: rd8 = st.irq_status;
            OFS_IRQ_MASK: rd8 = st.irq_mask;
            default: rd8 = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request sources
    always_comb begin
        match_full = (timer_count_full == timer_compare_full);
        match_hi = timer16 ? match_full
            : (timer_count_full[15:8] == timer_compare_full[15:8]);
        match_lo = !timer16 && (timer_count_full[7:0] == timer_compare_full[7:0]);
        set_periph = 8'h00;
        set_periph[BIT_DT] = sleep_direct_transition && st.ctrl[CTRL_DIRECT_TRANSITION_ON];
        set_periph[BIT_AD] = st.conv_prev && !conversion_running_status;
        // Only the start of a match sets, so a held match cannot refill a cleared flag
        set_periph[BIT_TFH] = match_hi && !st.match_hi_prev;
        set_periph[BIT_TFL] = match_lo && !st.match_lo_prev;
        set_periph[BIT_EC] = event_count_upper_ovf
            || (!event16 && event_count_lower_ovf);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        case (st.bus)
            IRF_BUS_IDLE: begin
                if (read || write) begin
                    next_st.bus = IRF_BUS_ACK;
                    next_st.waitrequest = 1'b0;
                    next_st.readdata = {24'h000000, rd8};
                end
            end
            IRF_BUS_ACK: begin
                next_st.bus = IRF_BUS_IDLE;
                next_st.waitrequest = 1'b1;
            end
            default: begin
                next_st.bus = IRF_BUS_IDLE;
                next_st.waitrequest = 1'b1;
            end
        endcase
        if (wr_lane) begin
            case (address)
                OFS_EDGE_SEL: next_st.edge_select = wdata8;
                OFS_WAKE_EN: next_st.wake_enable = wdata8;
                OFS_CTRL: next_st.ctrl = wdata8 & CTRL_IMPL;
                OFS_IRQ_MASK: next_st.irq_mask = wdata8 & IRQ_IMPL;
                default: next_st.ctrl = st.ctrl;
            endcase
        end
        next_st.conv_prev = conversion_running_status;
        next_st.match_hi_prev = match_hi;
        next_st.match_lo_prev = match_lo;
        irq_set = 8'h00;
        irq_set[IRQ_PERIPH] = |set_periph;
        irq_set[IRQ_WAKE] = |wake_hit;
        irq_clr = (wr_lane && (address == OFS_IRQ_STAT)) ? (wdata8 & IRQ_IMPL) : 8'h00;
        // Set wins over the write-one clear
        next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st.bus <= IRF_BUS_IDLE;
            st.waitrequest <= 1'b1;
            st.readdata <= RST_RDATA;
            st.edge_select <= RST_REG;
            st.wake_enable <= RST_REG;
            st.ctrl <= RST_REG;
            st.irq_status <= RST_REG;
            st.irq_mask <= RST_REG;
            st.conv_prev <= 1'b0;
            st.match_hi_prev <= 1'b0;
            st.match_lo_prev <= 1'b0;
            st.irq <= 1'b0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    irf_edge_detect #(
        .WIDTH(FLAG_W)
    ) u_edge (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .pin(wakeup_pin_n),
        .edge_select(st.edge_select),
        .pin_enable(st.wake_enable),
        .edge_hit(wake_hit)
    );

    // Reserved bits are masked, so stray ones written there are harmless
    irf_flag_reg #(
        .WIDTH(FLAG_W),
        .IMPL_MASK(PERIPH_IMPL)
    ) u_periph (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .set_req(set_periph),
        .clr_en(wr_periph),
        .clr_data(wdata8),
        .flags(periph_flags)
    );

    irf_flag_reg #(
        .WIDTH(FLAG_W),
        .IMPL_MASK(WAKE_IMPL)
    ) u_wake (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .set_req(wake_hit),
        .clr_en(wr_wake),
        .clr_data(wdata8),
        .flags(wake_flags)
    );

    assign readdata = st.readdata;
    assign waitrequest = st.waitrequest;
    assign peripheral_request_flags = periph_flags;
    assign wakeup_request_flags = wake_flags;
    assign irq = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_request;
        ce && (read || write) && waitrequest && (st.bus == IRF_BUS_IDLE);
    endsequence

    sequence s_answer;
        // A frozen cycle holds the answer for one more edge
        !waitrequest ##1 (waitrequest || !$past(ce));
    endsequence

    property p_bus_answer;
        s_request |=> s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("no answer after one wait");

    property p_dt_set;
        ce && sleep_direct_transition && st.ctrl[CTRL_DIRECT_TRANSITION_ON] |=> periph_flags[BIT_DT];
    endproperty
    a_dt_set: assert property (p_dt_set) else $error("direct transition flag not set");

    property p_ad_set;
        ce && st.conv_prev && !conversion_running_status |=> periph_flags[BIT_AD];
    endproperty
    a_ad_set: assert property (p_ad_set) else $error("conversion end flag not set");

    property p_tfh_set;
        ce && timer16 && match_full && !st.match_hi_prev |=> periph_flags[BIT_TFH];
    endproperty
    a_tfh_set: assert property (p_tfh_set) else $error("upper match flag not set");

    property p_tfl_quiet;
        ce && timer16 && !periph_flags[BIT_TFL] |=> !periph_flags[BIT_TFL];
    endproperty
    a_tfl_quiet: assert property (p_tfl_quiet) else $error("lower flag set in 16-bit mode");

    property p_ec_lower;
        ce && !event16 && event_count_lower_ovf |=> periph_flags[BIT_EC];
    endproperty
    a_ec_lower: assert property (p_ec_lower) else $error("event overflow flag not set");

    property p_sticky;
        ce && periph_flags[BIT_DT] && !wr_periph |=> periph_flags[BIT_DT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without write");

    property p_write_one_keeps;
        ce && wr_wake && (wdata8 == 8'hFF)
        |=> (wake_flags & $past(wake_flags)) == $past(wake_flags);
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) else $error("write one cleared");

    property p_wake_clear;
        ce && wr_wake && (wdata8 == 8'h00) && (wake_hit == 8'h00) |=> wake_flags == 8'h00;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wakeup flags not cleared");

    property p_set_wins;
        ce && wr_periph && !wdata8[BIT_EC] && event_count_upper_ovf |=> periph_flags[BIT_EC];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_irq_level;
        ce && (st.irq_mask == 8'h00) && !wr_lane |=> !irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq high while fully masked");

    property p_irq_follows;
        ce |=> irq == |(st.irq_status & st.irq_mask);
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not matching status");

    // Mode-specific set and hold checks, then clear, collision, wakeup and status clear checks
    property p_tfh8_set;
        ce && !timer16 && (timer_count_full[15:8] == timer_compare_full[15:8])
        && !st.match_hi_prev |=> periph_flags[BIT_TFH];
    endproperty
    a_tfh8_set: assert property (p_tfh8_set) else $error("upper byte match not flagged");

    property p_tfl_set;
        ce && !timer16 && (timer_count_full[7:0] == timer_compare_full[7:0])
        && !st.match_lo_prev |=> periph_flags[BIT_TFL];
    endproperty
    a_tfl_set: assert property (p_tfl_set) else $error("lower match not flagged");

    property p_ec_upper;
        ce && event_count_upper_ovf |=> periph_flags[BIT_EC];
    endproperty
    a_ec_upper: assert property (p_ec_upper) else $error("upper overflow not flagged");

    property p_ec16_quiet;
        ce && event16 && !event_count_upper_ovf && !periph_flags[BIT_EC]
        |=> !periph_flags[BIT_EC];
    endproperty
    a_ec16_quiet: assert property (p_ec16_quiet) else $error("lower overflow in 16-bit");

    property p_dt_quiet;
        ce && !st.ctrl[CTRL_DIRECT_TRANSITION_ON] && !periph_flags[BIT_DT] |=> !periph_flags[BIT_DT];
    endproperty
    a_dt_quiet: assert property (p_dt_quiet) else $error("direct flag set while off");

    property p_periph_clear;
        ce && wr_periph && (wdata8 == 8'h00) && (set_periph == 8'h00)
        |=> periph_flags == 8'h00;
    endproperty
    a_periph_clear: assert property (p_periph_clear) else $error("flags not cleared");

    property p_set_wins_tfh;
        ce && wr_periph && !wdata8[BIT_TFH] && timer16 && match_full && !st.match_hi_prev
        |=> periph_flags[BIT_TFH];
    endproperty
    a_set_wins_tfh: assert property (p_set_wins_tfh) else $error("match lost to clear");

    property p_wake_set;
        ce && (wake_hit != 8'h00) |=> (wake_flags & $past(wake_hit)) == $past(wake_hit);
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wakeup edge not flagged");

    property p_wake_sticky;
        ce && !wr_wake |=> (wake_flags & $past(wake_flags)) == $past(wake_flags);
    endproperty
    a_wake_sticky: assert property (p_wake_sticky) else $error("wakeup flag dropped");

    property p_irq_stat_clear;
        ce && wr_lane && (address == OFS_IRQ_STAT) && wdata8[IRQ_PERIPH]
        && (set_periph == 8'h00) |=> !st.irq_status[IRQ_PERIPH];
    endproperty
    a_irq_stat_clear: assert property (p_irq_stat_clear) else $error("status not cleared");
endmodule

// [include/irf_pkg.sv]
// Shared constants and types for the interrupt request flag block
package irf_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FLAG_W = 8;
    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PERIPH = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_WAKE = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_EDGE_SEL = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h18;
    ////////////////////////////////////////////////////////////////////////////
    // Peripheral flag positions; bits 5, 4 and 1 are reserved and read zero
    localparam int unsigned BIT_DT = 7;
    localparam int unsigned BIT_AD = 6;
    localparam int unsigned BIT_TFH = 3;
    localparam int unsigned BIT_TFL = 2;
    localparam int unsigned BIT_EC = 0;
    localparam logic [FLAG_W-1:0] PERIPH_IMPL = 8'hCD;
    localparam logic [FLAG_W-1:0] WAKE_IMPL = 8'hFF;
    ////////////////////////////////////////////////////////////////////////////
    // Control bits
    localparam int unsigned CTRL_DIRECT_TRANSITION_ON = 0;
    localparam int unsigned CTRL_TIMER16 = 1;
    localparam int unsigned CTRL_EVENT16 = 2;
    localparam logic [FLAG_W-1:0] CTRL_IMPL = 8'h07;
    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status bits
    localparam int unsigned IRQ_PERIPH = 0;
    localparam int unsigned IRQ_WAKE = 1;
    localparam logic [FLAG_W-1:0] IRQ_IMPL = 8'h03;
    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [FLAG_W-1:0] RST_FLAGS = 8'h00;
    localparam logic [FLAG_W-1:0] RST_REG = 8'h00;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h00000000;
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        IRF_BUS_IDLE = 2'b01,
        IRF_BUS_ACK = 2'b10
    } irf_bus_state_t;
endpackage

// [hdl/irf_flag_reg.sv]
// Sticky request flags, set by hardware, cleared by writing zero
`timescale 1ns/1ps
module irf_flag_reg #(
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL_MASK = 8'hFF
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] set_req,
    input wire logic clr_en,
    input wire logic [WIDTH-1:0] clr_data,
    output logic [WIDTH-1:0] flags
);
    import irf_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } irf_flag_state_t;

    irf_flag_state_t st;
    irf_flag_state_t next_st;
    logic [WIDTH-1:0] clr_bits;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Only zeros clear; ones leave the flag alone
        clr_bits = clr_en ? (~clr_data & IMPL_MASK) : '0;
        // No automatic clear; set wins over a clearing write
        next_st.flags = (st.flags & ~clr_bits) | (set_req & IMPL_MASK);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st.flags <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
endmodule

// [hdl/irf_edge_detect.sv]
// Per-pin wakeup edge detector with rising or falling select
`timescale 1ns/1ps
module irf_edge_detect #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    input wire logic [WIDTH-1:0] edge_select,
    input wire logic [WIDTH-1:0] pin_enable,
    output logic [WIDTH-1:0] edge_hit
);
    import irf_pkg::*;

    typedef struct packed {
        logic primed;
        logic [WIDTH-1:0] prev;
    } irf_edge_state_t;

    irf_edge_state_t st;
    irf_edge_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // No edge seen until one sample is held, so reset is not taken as an edge
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        assign edge_hit[i] = st.primed & pin_enable[i] &
            (edge_select[i] ? (~st.prev[i] & pin[i]) : (st.prev[i] & ~pin[i]));
    end

    always_comb begin
        next_st.primed = 1'b1;
        next_st.prev = pin;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    property p_fall_seen;
        @(posedge mclk) disable iff (!arst_n)
        st.primed && pin_enable[WIDTH-1] && !edge_select[WIDTH-1] && st.prev[WIDTH-1]
        && !pin[WIDTH-1] |-> edge_hit[WIDTH-1];
    endproperty
    a_fall_seen: assert property (p_fall_seen) else $error("falling edge not detected");

    property p_rise_seen;
        @(posedge mclk) disable iff (!arst_n)
        st.primed && pin_enable[0] && edge_select[0] && !st.prev[0] && pin[0] |-> edge_hit[0];
    endproperty
    a_rise_seen: assert property (p_rise_seen) else $error("rising edge not detected");
endmodule

// [bench/irf_src_model.sv]
// Behavioural model of the peripheral request sources
`timescale 1ns/1ps
module irf_src_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] fire,
    output logic sleep_direct_transition,
    output logic conversion_running_status,
    output logic event_count_upper_ovf,
    output logic event_count_lower_ovf
);
    // Pulses last one cycle; conversion status dips for one cycle per finished conversion
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_direct_transition <= 1'b0;
            conversion_running_status <= 1'b0;
            event_count_upper_ovf <= 1'b0;
            event_count_lower_ovf <= 1'b0;
        end else begin
            sleep_direct_transition <= fire[0];
            conversion_running_status <= ~fire[1];
            event_count_upper_ovf <= fire[2];
            event_count_lower_ovf <= fire[3];
        end
    end
endmodule

// [bench/irq_request_flag_regs_tb.sv]
// Self-checking bench for the interrupt request flag registers
`timescale 1ns/1ps
module irq_request_flag_regs_tb;
    import irf_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] fire;
        logic [15:0] cnt;
        logic [15:0] cmp;
        logic [7:0] exp;
    } irf_row_t;
    logic mclk;
    logic arst_n;
    logic read;
    logic write;
    logic sdt;
    logic crs;
    logic ecu;
    logic event_count_lower;
    logic ce;
    logic [3:0] be;
    logic waitrequest;
    logic irq;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [DATA_W-1:0] readdata;
    logic [DATA_W-1:0] rd;
    logic [3:0] fire;
    logic [15:0] tcnt;
    logic [15:0] tcmp;
    logic [7:0] pins;
    logic [7:0] pflags;
    logic [7:0] wflags;
    int errors;
    int check_count;
    irf_row_t rows [11];
    ////////////////////////////////////////////////////////////////////////////
    irf_top u_irf_top (
        .mclk(mclk),
        .arst_n(arst_n),
        .ce(ce),
        .address(address),
        .read(read),
        .write(write),
        .byteenable(be),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .sleep_direct_transition(sdt),
        .conversion_running_status(crs),
        .timer_count_full(tcnt),
        .timer_compare_full(tcmp),
        .event_count_upper_ovf(ecu),
        .event_count_lower_ovf(event_count_lower),
        .wakeup_pin_n(pins),
        .peripheral_request_flags(pflags),
        .wakeup_request_flags(wflags),
        .irq(irq)
    );
    irf_src_model u_irf_src_model (
        .mclk(mclk),
        .arst_n(arst_n),
        .fire(fire),
        .sleep_direct_transition(sdt),
        .conversion_running_status(crs),
        .event_count_upper_ovf(ecu),
        .event_count_lower_ovf(event_count_lower)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Optional tm lands a timer match on the write's effect edge and ends a fire pulse
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic tm = 1'b0);
        int i;
        address <= a;
        write <= w;
        read <= !w;
        writedata <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (waitrequest === 1'b0) break;
            if (tm) {tcnt, fire} <= {tcmp, 4'h0};
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
        if (i == 20) begin
            errors++;
            close_out();
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp, input string what);
        acc(1'b0, a, 8'h00);
        chk(rd[7:0], exp, what);
        chk(rd[31:24] | rd[23:16] | rd[15:8], 8'h00, "read upper");
    endtask
    // irq is registered, so let two edges pass before looking
    task automatic ichk(input logic exp);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, {7'h0, exp}, "irq");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        rows = '{
            {8'h00, 4'h1, 16'hFFFF, 16'h0000, 8'h00},
            {8'h01, 4'h1, 16'hFFFF, 16'h0000, 8'h80},
            {8'h00, 4'h2, 16'hFFFF, 16'h0000, 8'h40},
            {8'h00, 4'h0, 16'h1200, 16'h1255, 8'h08},
            {8'h00, 4'h0, 16'h0055, 16'h3455, 8'h04},
            {8'h02, 4'h0, 16'h0055, 16'h3455, 8'h00},
            {8'h02, 4'h0, 16'h3455, 16'h3455, 8'h08},
            {8'h02, 4'h0, 16'h3400, 16'h3455, 8'h00},
            {8'h04, 4'h4, 16'hFFFF, 16'h0000, 8'h01},
            {8'h04, 4'h8, 16'hFFFF, 16'h0000, 8'h00},
            {8'h00, 4'h8, 16'hFFFF, 16'h0000, 8'h01}
        };
        arst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        fire = 4'h0;
        tcnt = 16'hFFFF;
        tcmp = 16'h0000;
        pins = 8'hF0;
        ce = 1'b1;
        be = 4'hF;
        errors = 0;
        check_count = 0;
        repeat (8) @(posedge mclk);
        chk({7'h0, waitrequest}, 8'h01, "reset wait");
        chk(pflags | wflags, 8'h00, "reset flags");
        arst_n <= 1'b1;
        @(posedge mclk);
        // Reset values of every register and the unmapped word
        acc(1'b1, 5'h1C, 8'hFF);
        for (int a = 0; a < 32; a += 4) begin
            rchk(a[4:0], 8'h00, "reset reg");
        end
        $display("reset test done");
        foreach (rows[k]) begin
            acc(1'b1, OFS_CTRL, rows[k].ctrl);
            fire <= rows[k].fire;
            tcnt <= rows[k].cnt;
            tcmp <= rows[k].cmp;
            @(posedge mclk);
            fire <= 4'h0;
            tcnt <= 16'hFFFF;
            tcmp <= 16'h0000;
            repeat (3) @(posedge mclk);
            rchk(OFS_PERIPH, rows[k].exp, "row flags");
            chk(pflags, rows[k].exp, "row port");
            acc(1'b1, OFS_PERIPH, 8'h00);
            rchk(OFS_PERIPH, 8'h00, "row clear");
            $display("row %0d done", k);
        end
        // Interrupt: clear, raise, mask, unmask, clear
        acc(1'b1, OFS_IRQ_STAT, 8'h03);
        rchk(OFS_IRQ_STAT, 8'h00, "stat clr");
        acc(1'b1, OFS_IRQ_MASK, 8'h01);
        fire <= 4'h4;
        @(posedge mclk);
        fire <= 4'h0;
        ichk(1'b1);
        acc(1'b1, OFS_PERIPH, 8'hCD);
        rchk(OFS_PERIPH, 8'h01, "write one keeps");
        acc(1'b1, OFS_IRQ_MASK, 8'h00);
        ichk(1'b0);
        acc(1'b1, OFS_IRQ_MASK, 8'h01);
        ichk(1'b1);
        acc(1'b1, OFS_PERIPH, 8'h00);
        rchk(OFS_IRQ_STAT, 8'h01, "stat sticky");
        acc(1'b1, OFS_IRQ_STAT, 8'h01);
        ichk(1'b0);
        $display("interrupt test done");
        // Match arriving on the clearing edge must survive
        acc(1'b1, OFS_CTRL, 8'h02);
        tcmp <= 16'h3455;
        fire <= 4'h4;
        acc(1'b1, OFS_PERIPH, 8'h00, 1'b1);
        rchk(OFS_PERIPH, 8'h09, "set wins");
        tcnt <= 16'hFFFF;
        acc(1'b1, OFS_PERIPH, 8'h00);
        $display("collision test done");
        // Wakeup: low nibble senses rising, high nibble falling
        acc(1'b1, OFS_EDGE_SEL, 8'h0F);
        acc(1'b1, OFS_WAKE_EN, 8'hFF);
        pins <= 8'h0F;
        repeat (3) @(posedge mclk);
        rchk(OFS_WAKE, 8'hFF, "wake set");
        acc(1'b1, OFS_WAKE, 8'hFF);
        rchk(OFS_WAKE, 8'hFF, "wake write one");
        acc(1'b1, OFS_WAKE, 8'hF0);
        rchk(OFS_WAKE, 8'hF0, "wake part clr");
        acc(1'b1, OFS_WAKE, 8'h00);
        pins <= 8'hF0;
        repeat (3) @(posedge mclk);
        rchk(OFS_WAKE, 8'h00, "wrong edges");
        acc(1'b1, OFS_WAKE_EN, 8'h00);
        pins <= 8'h0F;
        repeat (3) @(posedge mclk);
        rchk(OFS_WAKE, 8'h00, "pins disabled");
        chk(wflags, 8'h00, "wake port");
        $display("wakeup test done");
        // Byte lane 0 off blocks a clear; clock enable low drops a source pulse
        fire <= 4'h4;
        @(posedge mclk);
        fire <= 4'h0;
        be <= 4'hE;
        acc(1'b1, OFS_PERIPH, 8'h00);
        be <= 4'hF;
        rchk(OFS_PERIPH, 8'h01, "lane off");
        acc(1'b1, OFS_PERIPH, 8'h00);
        ce <= 1'b0;
        fire <= 4'h4;
        @(posedge mclk);
        fire <= 4'h0;
        repeat (2) @(posedge mclk);
        ce <= 1'b1;
        @(posedge mclk);
        chk(pflags, 8'h00, "ce frozen");
        $display("awkward test done");
        // Reset in mid-run clears flags, registers and irq
        fire <= 4'h4;
        @(posedge mclk);
        fire <= 4'h0;
        repeat (2) @(posedge mclk);
        chk(pflags, 8'h01, "pre reset");
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(pflags | wflags | {7'h0, irq | ~waitrequest}, 8'h00, "in reset");
        arst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a < 32; a += 4) begin
            rchk(a[4:0], 8'h00, "after reset");
        end
        $display("mid reset test done");
        close_out();
    end
endmodule
